//--- rtl/cifc_pkg.sv
// Package for the CAN interrupt flag and mode handshake block.
// Assumes a single bus clock; protocol-engine events arrive as level toggles.
package cifc_pkg;

  localparam logic [2:0] CIFC_ADDR_CTL0  = 3'h0;
  localparam logic [2:0] CIFC_ADDR_RFLG  = 3'h1;
  localparam logic [2:0] CIFC_ADDR_RIER  = 3'h2;
  localparam logic [2:0] CIFC_ADDR_TFLG  = 3'h3;
  localparam logic [2:0] CIFC_ADDR_TIER  = 3'h4;

  // Control register 0 fields
  localparam int CIFC_CTL_INIT_REQUEST = 0;
  localparam int CIFC_CTL_SLEEP_REQUEST  = 1;
  localparam int CIFC_CTL_WAKEEN = 2;
  localparam int CIFC_CTL_MODEN  = 3;
  localparam int CIFC_CTL_SLEEP_ACK  = 4;
  localparam int CIFC_CTL_INIT_ACK = 5;

  // Receive flag register fields
  localparam int CIFC_RF_RXF  = 0;
  localparam int CIFC_RF_OVR  = 1;
  localparam int CIFC_RF_TST  = 2;
  localparam int CIFC_RF_RST  = 4;
  localparam int CIFC_RF_CSC  = 6;
  localparam int CIFC_RF_WAKE = 7;

  // Receive enable register fields
  localparam int CIFC_RE_RXF  = 0;
  localparam int CIFC_RE_OVR  = 1;
  localparam int CIFC_RE_CSC  = 6;
  localparam int CIFC_RE_WAKE = 7;

  localparam int CIFC_NTX = 3;

  localparam logic [7:0] CIFC_CTL0_RST = 8'h01;
  localparam logic [7:0] CIFC_ZERO8    = 8'h00;
  localparam logic [2:0] CIFC_TXE_RST  = 3'h7;

  // Init ack synchronisation: two bus clocks plus three CAN clocks
  localparam logic [2:0] CIFC_INIT_BUS_DLY = 3'h2;
  localparam logic [2:0] CIFC_INIT_CAN_DLY = 3'h3;

  typedef enum logic [1:0] {
    CIFC_RUN      = 2'b00,
    CIFC_SLEEP_WT = 2'b01,
    CIFC_SLEEP    = 2'b10
  } cifc_slp_e;

  typedef enum logic [1:0] {
    CIFC_NORM   = 2'b00,
    CIFC_INI_WB = 2'b01,
    CIFC_INI_WC = 2'b10,
    CIFC_INIT   = 2'b11
  } cifc_ini_e;

  typedef struct packed {
    logic       rx_done;
    logic       rx_overrun;
    logic       bus_activity;
    logic       state_change;
    logic [1:0] tx_state;
    logic [1:0] rx_state;
    logic [2:0] tx_buf_busy;
    logic       tx_active;
    logic       rx_active;
  } cifc_eng_s;

  typedef struct packed {
    logic wake;
    logic error;
    logic receive;
    logic transmit;
  } cifc_irq_s;

endpackage

//--- rtl/cifc_top.sv
// CAN interrupt flag, mask and init/sleep handshake logic.
// Assumes engine status comes from the CAN domain and is resynchronised here.
// Summary of operation
// RL1 - Four maskable interrupt request outputs
// RL2 - Error request joins status change and overrun
// RL3 - Three tx empty flags, each separately enabled
// RL4 - Rx full set when frame reaches foreground
// RL5 - Rx full set again for next queued frame
// RL6 - Wake flag on activity in sleep, if enabled
// RL7 - Overrun flag on frame with FIFO full
// RL8 - Status change flag with tx/rx state fields
// RL9 - Request holds while enabled flag stays set
// RL10 - Flags clear only by writing one
// RL11 - Clear ignored while set condition persists
// RL12 - Handler clears only its own flag bit
// RL13 - Stop/wait wake needs prior sleep and enables
// RL14 - Host enables, configures in init, leaves init
// RL15 - Reconfigure via sleep, then init handshake
// RL16 - Init mode resets control and flag registers
// RL17 - Init ack after two bus, three CAN clocks
// RL18 - Sleep ack waits for transmissions and idle
// RL19 - Init request clear ignored before ack
// RL20 - Requests are registered OR of enabled flags
// RL21 - CAN events synchronised; set beats clear
`timescale 1ns/1ps
`default_nettype none
module cifc_top
  import cifc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       can_tick_i,
  input  wire logic       power_down_i,
  input  wire cifc_eng_s  eng_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output cifc_irq_s       irq_o,
  output logic            init_mode_o,
  output logic            sleep_mode_o
);

  cifc_eng_s  eng_s1;
  cifc_eng_s  eng_s2;
  cifc_eng_s  eng_prev;
  logic       tick_s1;
  logic       tick_s2;
  logic       pd_s1;
  logic       pd_s2;

  logic       init_request;
  logic       sleep_request;
  logic       wake_enable;
  logic       module_enable;
  logic       rx_full_flag;
  logic       overrun_flag;
  logic       status_change_flag;
  logic       wake_flag;
  logic [1:0] tx_bus_state;
  logic [1:0] rx_bus_state;
  logic       rx_full_irq_enable;
  logic       overrun_irq_enable;
  logic       status_change_irq_enable;
  logic       wake_irq_enable;
  logic [2:0] tx_empty_flags;
  logic [2:0] tx_empty_irq_enables;
  logic       pd_slept;

  cifc_slp_e  slp_st;
  cifc_ini_e  ini_st;
  logic [2:0] dly_cnt;

  logic       sleep_ack;
  logic       init_ack;
  logic       set_rxf;
  logic       set_ovr;
  logic       set_csc;
  logic       set_wake;
  logic       wr_ctl;
  logic       wr_rflg;
  logic       wr_rier;
  logic       wr_tflg;
  logic       wr_tier;
  logic       in_init;

  // Engine crosses from CAN clock; two stages before any use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eng_s1   <= '0;
      eng_s2   <= '0;
      eng_prev <= '0;
      tick_s1  <= 1'b0;
      tick_s2  <= 1'b0;
      pd_s1    <= 1'b0;
      pd_s2    <= 1'b0;
    end else begin
      eng_s1   <= eng_i; // RL21
      eng_s2   <= eng_s1;
      eng_prev <= eng_s2;
      tick_s1  <= can_tick_i;
      tick_s2  <= tick_s1;
      pd_s1    <= power_down_i;
      pd_s2    <= pd_s1;
    end
  end

  // Event levels are toggles at the engine; edge of the synced copy is the event
  assign set_rxf  = (eng_s2.rx_done ^ eng_prev.rx_done) && !sleep_ack; // RL4
  assign set_ovr  = eng_s2.rx_overrun ^ eng_prev.rx_overrun; // RL7
  assign set_csc  = eng_s2.state_change ^ eng_prev.state_change; // RL8
  assign set_wake = sleep_ack && wake_enable && eng_s2.bus_activity; // RL6

  assign sleep_ack = (slp_st == CIFC_SLEEP);
  assign init_ack  = (ini_st == CIFC_INIT);
  assign in_init   = init_ack;

  assign wr_ctl  = wr_i && (addr_i == CIFC_ADDR_CTL0);
  assign wr_rflg = wr_i && (addr_i == CIFC_ADDR_RFLG);
  assign wr_rier = wr_i && (addr_i == CIFC_ADDR_RIER);
  assign wr_tflg = wr_i && (addr_i == CIFC_ADDR_TFLG);
  assign wr_tier = wr_i && (addr_i == CIFC_ADDR_TIER);

  // Control register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_request  <= CIFC_CTL0_RST[CIFC_CTL_INIT_REQUEST];
      sleep_request <= CIFC_CTL0_RST[CIFC_CTL_SLEEP_REQUEST];
      wake_enable   <= CIFC_CTL0_RST[CIFC_CTL_WAKEEN];
      module_enable <= CIFC_CTL0_RST[CIFC_CTL_MODEN];
    end else if (wr_ctl) begin
      module_enable <= wdata_i[CIFC_CTL_MODEN];
      if (wdata_i[CIFC_CTL_INIT_REQUEST] || init_ack)
        init_request <= wdata_i[CIFC_CTL_INIT_REQUEST]; // RL19
      if (in_init) begin
        sleep_request <= 1'b0; // RL16
        wake_enable   <= 1'b0;
      end else begin
        // Sleep request cannot drop until sleep is reached
        if (wdata_i[CIFC_CTL_SLEEP_REQUEST] || sleep_ack)
          sleep_request <= wdata_i[CIFC_CTL_SLEEP_REQUEST];
        wake_enable <= wdata_i[CIFC_CTL_WAKEEN];
      end
    end else if (in_init) begin
      sleep_request <= 1'b0; // RL16
      wake_enable   <= 1'b0;
    end else if (set_wake) begin
      sleep_request <= 1'b0;
    end
  end

  // Sleep handshake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slp_st <= CIFC_RUN;
    end else begin
      case (slp_st)
        CIFC_RUN:
          if (sleep_request && !init_request)
            slp_st <= CIFC_SLEEP_WT;
        CIFC_SLEEP_WT:
          if (!sleep_request)
            slp_st <= CIFC_RUN;
          else if (eng_s2.tx_buf_busy == '0 && !eng_s2.tx_active && !eng_s2.rx_active)
            slp_st <= CIFC_SLEEP; // RL18
        CIFC_SLEEP:
          if (!sleep_request || in_init)
            slp_st <= CIFC_RUN;
        default:
          slp_st <= CIFC_RUN;
      endcase
    end
  end

  // Init handshake: bus clocks, then CAN clocks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ini_st  <= CIFC_INIT;
      dly_cnt <= '0;
    end else begin
      case (ini_st)
        CIFC_NORM:
          if (init_request) begin
            ini_st  <= CIFC_INI_WB;
            dly_cnt <= '0;
          end
        CIFC_INI_WB:
          if (dly_cnt == CIFC_INIT_BUS_DLY - 3'h1) begin
            ini_st  <= CIFC_INI_WC;
            dly_cnt <= '0;
          end else begin
            dly_cnt <= dly_cnt + 3'h1;
          end
        CIFC_INI_WC:
          if (tick_s2) begin
            if (dly_cnt == CIFC_INIT_CAN_DLY - 3'h1)
              ini_st <= CIFC_INIT; // RL17
            else
              dly_cnt <= dly_cnt + 3'h1;
          end
        CIFC_INIT:
          if (!init_request)
            ini_st <= CIFC_NORM;
        default:
          ini_st <= CIFC_INIT;
      endcase
    end
  end

  // Receive flags; set has priority over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_full_flag       <= 1'b0;
      overrun_flag       <= 1'b0;
      status_change_flag <= 1'b0;
      wake_flag          <= 1'b0;
      tx_bus_state       <= '0;
      rx_bus_state       <= '0;
    end else if (in_init) begin
      rx_full_flag       <= 1'b0; // RL16
      overrun_flag       <= 1'b0;
      status_change_flag <= 1'b0;
      wake_flag          <= 1'b0;
      tx_bus_state       <= '0;
      rx_bus_state       <= '0;
    end else begin
      if (set_rxf)
        rx_full_flag <= 1'b1; // RL5
      else if (wr_rflg && wdata_i[CIFC_RF_RXF])
        rx_full_flag <= 1'b0; // RL10
      if (set_ovr)
        overrun_flag <= 1'b1;
      else if (wr_rflg && wdata_i[CIFC_RF_OVR])
        overrun_flag <= 1'b0;
      if (set_csc) begin
        status_change_flag <= 1'b1;
        tx_bus_state       <= eng_s2.tx_state; // RL8
        rx_bus_state       <= eng_s2.rx_state;
      end else if (wr_rflg && wdata_i[CIFC_RF_CSC]) begin
        status_change_flag <= 1'b0;
      end
      // Wake condition is a level; clear has no effect while it lasts
      if (set_wake)
        wake_flag <= 1'b1; // RL21
      else if (wr_rflg && wdata_i[CIFC_RF_WAKE])
        wake_flag <= 1'b0; // RL11
    end
  end

  // Enable registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_full_irq_enable       <= 1'b0;
      overrun_irq_enable       <= 1'b0;
      status_change_irq_enable <= 1'b0;
      wake_irq_enable          <= 1'b0;
      tx_empty_irq_enables     <= '0;
    end else if (in_init) begin
      rx_full_irq_enable       <= 1'b0; // RL16
      overrun_irq_enable       <= 1'b0;
      status_change_irq_enable <= 1'b0;
      wake_irq_enable          <= 1'b0;
      tx_empty_irq_enables     <= '0;
    end else begin
      if (wr_rier) begin
        rx_full_irq_enable       <= wdata_i[CIFC_RE_RXF];
        overrun_irq_enable       <= wdata_i[CIFC_RE_OVR];
        status_change_irq_enable <= wdata_i[CIFC_RE_CSC];
        wake_irq_enable          <= wdata_i[CIFC_RE_WAKE];
      end
      if (wr_tier)
        tx_empty_irq_enables <= wdata_i[CIFC_NTX-1:0];
    end
  end

  // Transmit empty flags: buffer busy in engine means scheduled
  generate
    for (genvar b = 0; b < CIFC_NTX; b++) begin : g_txe
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
          tx_empty_flags[b] <= CIFC_TXE_RST[b];
        else if (in_init || !eng_s2.tx_buf_busy[b])
          tx_empty_flags[b] <= 1'b1; // RL3
        else if (wr_tflg && wdata_i[b])
          tx_empty_flags[b] <= 1'b0; // RL10
      end
    end
  endgenerate

  // Power down only wakes if sleep was acknowledged beforehand
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      pd_slept <= 1'b0;
    else if (!pd_s2)
      pd_slept <= sleep_ack;
  end

  // Registered interrupt requests
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= '0;
    end else begin
      irq_o.wake <= wake_flag && wake_irq_enable
                    && (!pd_s2 || (pd_slept && wake_enable)); // RL13
      irq_o.error <= (status_change_flag && status_change_irq_enable)
                     || (overrun_flag && overrun_irq_enable); // RL2
      irq_o.receive <= rx_full_flag && rx_full_irq_enable; // RL9
      irq_o.transmit <= |(tx_empty_flags & tx_empty_irq_enables); // RL20
    end
  end // RL1

  // Register read, one cycle later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= CIFC_ZERO8;
    end else if (rd_i) begin
      case (addr_i)
        CIFC_ADDR_CTL0:
          rdata_o <= {2'b00, init_ack, sleep_ack, module_enable,
                      wake_enable, sleep_request, init_request};
        CIFC_ADDR_RFLG:
          rdata_o <= {wake_flag, status_change_flag, rx_bus_state,
                      tx_bus_state, overrun_flag, rx_full_flag};
        CIFC_ADDR_RIER:
          rdata_o <= {wake_irq_enable, status_change_irq_enable, 4'h0,
                      overrun_irq_enable, rx_full_irq_enable};
        CIFC_ADDR_TFLG:
          rdata_o <= {5'h00, tx_empty_flags};
        CIFC_ADDR_TIER:
          rdata_o <= {5'h00, tx_empty_irq_enables};
        default:
          rdata_o <= CIFC_ZERO8;
      endcase
    end else begin
      rdata_o <= CIFC_ZERO8;
    end
  end

  assign init_mode_o  = init_ack;
  assign sleep_mode_o = sleep_ack;

endmodule
`default_nettype wire

//--- test/cifc_sva.sv
// Port checker for the CAN interrupt flag and mode handshake block.
// Assumes one bus clock domain and the register map of cifc_pkg.
`timescale 1ns/1ps
`default_nettype none
module cifc_sva
  import cifc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire cifc_irq_s  irq_o,
  input wire logic       init_mode_o,
  input wire logic       sleep_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence ctl_wr_s;
    wr_i && addr_i == CIFC_ADDR_CTL0;
  endsequence
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  chk_tx_mask: assert property (wr_i && addr_i == CIFC_ADDR_TIER && wdata_i[2:0] == 3'h0
    |-> ##3 !irq_o.transmit) else $error("transmit request not masked");
  chk_rx_zero_write: assert property (irq_o.receive && wr_i && addr_i == CIFC_ADDR_RFLG
    && !wdata_i[CIFC_RF_RXF] |-> ##3 irq_o.receive) else $error("rx flag lost on zero write");
  chk_init_leave: assert property (ctl_wr_s ##0 (init_mode_o && !wdata_i[CIFC_CTL_INIT_REQUEST])
    |-> ##[1:2] !init_mode_o) else $error("init mode not left");
  chk_init_min_delay: assert property (ctl_wr_s ##0 (!init_mode_o && wdata_i[CIFC_CTL_INIT_REQUEST])
    |=> !init_mode_o [*4]) else $error("init ack too early");
  chk_irq_quiet_init: assert property (init_mode_o [*3] |-> irq_o == '0)
    else $error("request active in init mode");
  chk_txe_init_read: assert property (rd_i && addr_i == CIFC_ADDR_TFLG && init_mode_o
    && $past(init_mode_o) |=> rdata_o[2:0] == CIFC_TXE_RST)
    else $error("tx empty flags not set in init");
  chk_ack_readback: assert property (rd_i && addr_i == CIFC_ADDR_CTL0
    |=> rdata_o[CIFC_CTL_INIT_ACK] == $past(init_mode_o)
    && rdata_o[CIFC_CTL_SLEEP_ACK] == $past(sleep_mode_o)) else $error("ack bits differ from pins");
endmodule
bind cifc_top cifc_sva u_cifc_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .init_mode_o(init_mode_o), .sleep_mode_o(sleep_mode_o));
`default_nettype wire

//--- test/cifc_eng_model.sv
// Behavioural protocol engine driving the block's engine-side inputs.
// Assumes the bench pulses ev_i for one cycle per event.
`timescale 1ns/1ps
`default_nettype none
module cifc_eng_model
  import cifc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [2:0] ev_i,
  input  wire logic [2:0] busy_i,
  input  wire logic [1:0] state_i,
  input  wire logic       act_i,
  output cifc_eng_s       eng_o,
  output logic            can_tick_o
);
  logic [1:0] div = 2'h0;
  cifc_eng_s  eng = '0;
  // CAN clock runs free at a third of the bus rate
  always @(posedge clk_i) div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
  assign can_tick_o = (div == 2'h0);
  // Events are toggles so none is lost across the synchroniser
  always @(posedge clk_i) begin
    eng.rx_done      <= eng.rx_done ^ ev_i[0];
    eng.rx_overrun   <= eng.rx_overrun ^ ev_i[1];
    eng.state_change <= eng.state_change ^ ev_i[2];
    eng.tx_state     <= state_i;
    eng.rx_state     <= state_i;
    eng.tx_buf_busy  <= busy_i;
    eng.tx_active    <= |busy_i;
    eng.bus_activity <= act_i;
  end
  assign eng_o = eng;
endmodule
`default_nettype wire

//--- test/can_interrupt_flag_and_init_control_bench.sv
// Self-checking bench for the CAN interrupt flag and mode handshake block.
// Assumes the engine model and the bound checker; power-down driven here.
`timescale 1ns/1ps
`default_nettype none
module can_interrupt_flag_and_init_control_bench
  import cifc_pkg::*;
;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [2:0] addr_i  = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i    = 1'b0;
  logic       rd_i    = 1'b0;
  logic [2:0] ev      = 3'h0;
  logic [2:0] busy    = 3'h0;
  logic [1:0] st      = 2'h0;
  logic       act     = 1'b0;
  logic       pd      = 1'b0;
  logic [7:0] rdata_o;
  cifc_irq_s  irq_o;
  cifc_eng_s  eng;
  logic       init_mode_o;
  logic       sleep_mode_o;
  logic       can_tick;
  logic [5:0] obs;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         waited;
  always #2 clk_i = ~clk_i;
  assign obs = {sleep_mode_o, init_mode_o, irq_o};
  cifc_eng_model u_cifc_eng_model (.clk_i(clk_i), .ev_i(ev), .busy_i(busy), .state_i(st),
    .act_i(act), .eng_o(eng), .can_tick_o(can_tick));
  cifc_top u_cifc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .can_tick_i(can_tick),
    .power_down_i(pd), .eng_i(eng), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .init_mode_o(init_mode_o),
    .sleep_mode_o(sleep_mode_o));
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // Idle edge so a following call never re-drives the strobe in this step
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i) check(rdata_o, exp);
    @(posedge clk_i);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev[k] <= 1'b0;
  endtask
  // Bounded wait, sampled mid-cycle; the count is kept for the delay check
  task automatic wait_bit(input int b, input logic v);
    @(negedge clk_i);
    for (waited = 0; obs[b] !== v; waited++) begin
      if (waited == 200) begin
        error_cnt++;
        print_verdict();
      end
      @(negedge clk_i);
    end
    // Back on the rising edge so the next request starts there
    @(posedge clk_i);
  endtask
  task automatic t_reset();
    @(negedge clk_i);
    check({7'h0, init_mode_o}, 8'h01);
    check({4'h0, irq_o}, 8'h00);
    @(posedge clk_i);
    rdc(CIFC_ADDR_TFLG, 8'h07);
    rdc(3'h7, 8'h00);
  endtask
  task automatic t_leave();
    wr(CIFC_ADDR_CTL0, 8'h08);
    wait_bit(4, 1'b0);
    rdc(CIFC_ADDR_CTL0, 8'h08);
  endtask
  task automatic t_tx();
    wr(CIFC_ADDR_TIER, 8'h07);
    wait_bit(0, 1'b1);
    wr(CIFC_ADDR_TFLG, 8'h01);
    rdc(CIFC_ADDR_TFLG, 8'h07);
    busy <= 3'h1;
    repeat (4) @(posedge clk_i);
    wr(CIFC_ADDR_TFLG, 8'h01);
    wr(CIFC_ADDR_TIER, 8'h01);
    rdc(CIFC_ADDR_TFLG, 8'h06);
    wait_bit(0, 1'b0);
    busy <= 3'h0;
    wait_bit(0, 1'b1);
    wr(CIFC_ADDR_TIER, 8'h00);
    wait_bit(0, 1'b0);
  endtask
  task automatic t_rx();
    wr(CIFC_ADDR_RIER, 8'h43);
    // Two frames in turn, the second only after the first is cleared
    repeat (2) begin
      pulse(0);
      wait_bit(1, 1'b1);
      wr(CIFC_ADDR_RFLG, 8'h00);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i) check({7'h0, obs[1]}, 8'h01);
      @(posedge clk_i);
      wr(CIFC_ADDR_RFLG, 8'h01);
      wait_bit(1, 1'b0);
    end
  endtask
  task automatic t_err();
    pulse(1);
    wait_bit(2, 1'b1);
    wr(CIFC_ADDR_RFLG, 8'h02);
    wait_bit(2, 1'b0);
    st <= 2'h2;
    pulse(2);
    wait_bit(2, 1'b1);
    rdc(CIFC_ADDR_RFLG, 8'h68);
    wr(CIFC_ADDR_RFLG, 8'h40);
    wait_bit(2, 1'b0);
  endtask
  task automatic t_reinit();
    wr(CIFC_ADDR_CTL0, 8'h0A);
    wait_bit(5, 1'b1);
    wr(CIFC_ADDR_CTL0, 8'h0B);
    // Early clear of the init request must be ignored
    wr(CIFC_ADDR_CTL0, 8'h0A);
    wait_bit(4, 1'b1);
    check({7'h0, waited >= 4}, 8'h01);
    rdc(CIFC_ADDR_CTL0, 8'h29);
    rdc(CIFC_ADDR_RIER, 8'h00);
    rdc(CIFC_ADDR_TIER, 8'h00);
    wr(CIFC_ADDR_CTL0, 8'h08);
    wait_bit(4, 1'b0);
    rdc(CIFC_ADDR_CTL0, 8'h08);
  endtask
  // Bus activity in sleep with power-down already active
  task automatic t_wake();
    wr(CIFC_ADDR_RIER, 8'h80);
    wr(CIFC_ADDR_CTL0, 8'h0E);
    wait_bit(5, 1'b1);
    pd  <= 1'b1;
    act <= 1'b1;
    wait_bit(3, 1'b1);
    rdc(CIFC_ADDR_RFLG, 8'h80);
    rdc(CIFC_ADDR_CTL0, 8'h0C);
    act <= 1'b0;
    wr(CIFC_ADDR_CTL0, 8'h08);
    wait_bit(3, 1'b0);
    pd <= 1'b0;
    wait_bit(3, 1'b1);
    wr(CIFC_ADDR_RFLG, 8'h80);
    wait_bit(3, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_leave();
    t_tx();
    t_rx();
    t_err();
    t_reinit();
    t_wake();
    print_verdict();
  end
endmodule
`default_nettype wire
